// ---- shared/srx_defines.svh ----
// Register offsets, field positions, reset values and event indices
`ifndef SRX_DEFINES_SVH
`define SRX_DEFINES_SVH

`define SRX_ADDR_EXIT_CFG   8'h37
`define SRX_ADDR_CTRL       8'h3e
`define SRX_ADDR_STATUS     8'h3f

`define SRX_EXIT_CFG_RESET  8'h00
`define SRX_RX_EXIT_HI      7
`define SRX_RX_EXIT_LO      5
`define SRX_TO_EXIT_HI      4
`define SRX_TO_EXIT_LO      3
`define SRX_PR_EXIT_HI      2
`define SRX_PR_EXIT_LO      0

`define SRX_CTRL_START      0
`define SRX_CTRL_STOP       1
`define SRX_CTRL_LP_SEL     2
`define SRX_CTRL_IDLE_MODE  3

`define SRX_STAT_STATE_HI   2
`define SRX_STAT_STATE_LO   0
`define SRX_STAT_MODE_HI    4
`define SRX_STAT_MODE_LO    3

`define SRX_EVENT_COUNT     9
`define SRX_EV_PAYLOAD      0
`define SRX_EV_CHECKSUM     1
`define SRX_EV_RSSI         2
`define SRX_EV_SYNC         3
`define SRX_EV_PREAMBLE     4
`define SRX_EV_TO_RSSI      5
`define SRX_EV_TO_PREAMBLE  6
`define SRX_EV_TO_SYNC      7
`define SRX_EV_BUF_EMPTY    8

`endif

// ---- shared/srx_pkg.sv ----
// Types of the receive-exit sequencer block
`include "srx_defines.svh"
package srx_pkg;
	typedef enum logic [2:0] {
		ST_HALTED   = 3'b000,
		ST_IDLE     = 3'b001,
		ST_RECEIVE  = 3'b010,
		ST_PKT_RCVD = 3'b011,
		ST_TRANSMIT = 3'b100,
		ST_SYNTH    = 3'b101
	} srx_state_e;

	typedef enum logic [1:0] {
		MODE_INITIAL = 2'b00,
		MODE_STANDBY = 2'b01,
		MODE_SLEEP   = 2'b10,
		MODE_ACTIVE  = 2'b11
	} srx_mode_e;

	typedef enum logic [2:0] {
		RX_UNUSED0  = 3'b000,
		RX_PAY_PKT  = 3'b001,
		RX_PAY_LP   = 3'b010,
		RX_CRC_PKT  = 3'b011,
		RX_RSSI_OFF = 3'b100,
		RX_SYNC_OFF = 3'b101,
		RX_PRE_OFF  = 3'b110,
		RX_UNUSED7  = 3'b111
	} srx_rx_exit_e;

	typedef enum logic [1:0] {
		TO_RELAUNCH = 2'b00,
		TO_TRANSMIT = 2'b01,
		TO_LOWPOWER = 2'b10,
		TO_HALT     = 2'b11
	} srx_to_exit_e;

	typedef enum logic [2:0] {
		PR_HALT     = 3'b000,
		PR_TX_EMPTY = 3'b001,
		PR_LOWPOWER = 3'b010,
		PR_RX_SYNTH = 3'b011,
		PR_RX_DIRECT = 3'b100
	} srx_pr_exit_e;

	typedef struct packed {
		srx_state_e state;
		srx_mode_e  mode;
		logic       relaunch;
		logic       fired;
	} srx_main_s;

	typedef struct packed {
		logic [`SRX_EVENT_COUNT-1:0] prev;
	} srx_edge_s;

	typedef struct packed {
		logic [7:0] exitCfg;
		logic       lpSel;
		logic       idleMode;
		logic       startPulse;
		logic       stopPulse;
		logic [7:0] rdata;
	} srx_regs_s;
endpackage

// ---- design/srx_event_edge.sv ----
// Rising-edge detector over the interrupt flags
`timescale 1ns/1ps
`include "srx_defines.svh"
module srx_event_edge
	import srx_pkg::*;
#(
	parameter int N = `SRX_EVENT_COUNT
) (
	input  wire logic         mclk,
	input  wire logic         rst,
	input  wire logic         ce,
	input  wire logic [N-1:0] flags,
	output logic      [N-1:0] rise
);
	srx_edge_s r;
	srx_edge_s n;

	if (N != `SRX_EVENT_COUNT) begin : g_check
		$error("srx_event_edge: N must match the event count");
	end

	// A held flag fires its transition only once
	for (genvar i = 0; i < N; i++) begin : g_bit
		assign rise[i] = flags[i] & ~r.prev[i];
	end

	always_comb begin
		n = r;
		n.prev = flags;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			r <= '0;
		end else if (ce) begin
			r <= n;
		end
	end
endmodule

// ---- design/srx_regfile.sv ----
// Register slave: exit configuration, control and status
`timescale 1ns/1ps
`include "srx_defines.svh"
module srx_regfile
	import srx_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       ce,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	input  srx_state_e      seqState,
	input  srx_mode_e       chipMode,
	output logic      [7:0] exitCfg,
	output logic            lpSel,
	output logic            idleMode,
	output logic            startPulse,
	output logic            stopPulse
);
	srx_regs_s r;
	srx_regs_s n;

	always_comb begin
		n = r;
		n.startPulse = 1'b0;
		n.stopPulse = 1'b0;
		// Read data stands for exactly one cycle
		n.rdata = 8'h00;
		if (wr) begin
			case (addr)
				`SRX_ADDR_EXIT_CFG: n.exitCfg = wdata;
				`SRX_ADDR_CTRL: begin
					n.startPulse = wdata[`SRX_CTRL_START];
					n.stopPulse = wdata[`SRX_CTRL_STOP];
					n.lpSel = wdata[`SRX_CTRL_LP_SEL];
					n.idleMode = wdata[`SRX_CTRL_IDLE_MODE];
				end
				default: n = n;
			endcase
		end
		if (rd) begin
			case (addr)
				`SRX_ADDR_EXIT_CFG: n.rdata = r.exitCfg;
				`SRX_ADDR_CTRL: begin
					n.rdata[`SRX_CTRL_LP_SEL] = r.lpSel;
					n.rdata[`SRX_CTRL_IDLE_MODE] = r.idleMode;
				end
				`SRX_ADDR_STATUS: begin
					n.rdata[`SRX_STAT_STATE_HI:`SRX_STAT_STATE_LO] = seqState;
					n.rdata[`SRX_STAT_MODE_HI:`SRX_STAT_MODE_LO] = chipMode;
				end
				default: n.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			r <= '{exitCfg: `SRX_EXIT_CFG_RESET, default: '0};
		end else if (ce) begin
			r <= n;
		end
	end

	assign rdata = r.rdata;
	assign exitCfg = r.exitCfg;
	assign lpSel = r.lpSel;
	assign idleMode = r.idleMode;
	assign startPulse = r.startPulse;
	assign stopPulse = r.stopPulse;
endmodule

// ---- design/srx_sequencer_rx_exit.sv ----
// Sequencer exits from the Receive and packet-received states
//
// Behaviour
// - Receive-exit selector bits 7-5; 000/111 unused.
// - 001: payload complete goes to packet-received.
// - 010: payload complete takes low-power transition.
// - 011: checksum pass goes to packet-received.
// - 100: signal strength flag halts the sequencer.
// - 101 sync match, 110 preamble: halt.
// - Timeout-exit bits 4-3 select timeout action.
// - Any of three timeouts is receive timeout.
// - Packet-received exit: halt, transmit-on-empty, low-power.
// - 011 via synth mode if frequency changed, else direct; 100 direct receive.
// - Low-power select: halt-initial or idle standby/sleep.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "srx_defines.svh"
module srx_sequencer_rx_exit
	import srx_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       ce,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	input  wire logic       payloadCompleteFlag,
	input  wire logic       checksumPassFlag,
	input  wire logic       rssiFlag,
	input  wire logic       syncWordMatchFlag,
	input  wire logic       preambleFoundFlag,
	input  wire logic       signalStrengthTimeout,
	input  wire logic       preambleTimeout,
	input  wire logic       syncSignalTimeout,
	input  wire logic       bufferEmptyFlag,
	input  wire logic       freqChanged,
	input  wire logic       synthReady,
	output srx_state_e      seqState,
	output srx_mode_e       chipMode,
	output logic            receiveRelaunch,
	output logic            transitionFired
);
	srx_main_s r;
	srx_main_s n;

	logic [7:0]                  exitCfg;
	logic                        lpSel;
	logic                        idleMode;
	logic                        startPulse;
	logic                        stopPulse;
	logic [`SRX_EVENT_COUNT-1:0] flags;
	logic [`SRX_EVENT_COUNT-1:0] rise;
	srx_rx_exit_e                rxExit;
	srx_to_exit_e                toExit;
	srx_pr_exit_e                prExit;
	logic                        receive_timeout_event;
	srx_state_e                  lpState;
	srx_mode_e                   lpMode;

	// Field macros must agree with the enum widths, or the casts below cut codes
	if (`SRX_RX_EXIT_HI - `SRX_RX_EXIT_LO + 1 != $bits(srx_rx_exit_e)) begin : g_rx_field
		$error("srx_sequencer_rx_exit: receive-exit field width differs from its type");
	end
	if (`SRX_TO_EXIT_HI - `SRX_TO_EXIT_LO + 1 != $bits(srx_to_exit_e)) begin : g_to_field
		$error("srx_sequencer_rx_exit: timeout-exit field width differs from its type");
	end
	if (`SRX_PR_EXIT_HI - `SRX_PR_EXIT_LO + 1 != $bits(srx_pr_exit_e)) begin : g_pr_field
		$error("srx_sequencer_rx_exit: packet-exit field width differs from its type");
	end
	if (`SRX_RX_EXIT_HI > 7) begin : g_cfg_span
		$error("srx_sequencer_rx_exit: exit fields must sit inside the 8-bit register");
	end
	// Status read-back packs state and mode into fixed fields
	if (`SRX_STAT_STATE_HI - `SRX_STAT_STATE_LO + 1 != $bits(srx_state_e)) begin : g_st_field
		$error("srx_sequencer_rx_exit: status state field width differs from its type");
	end
	if (`SRX_STAT_MODE_HI - `SRX_STAT_MODE_LO + 1 != $bits(srx_mode_e)) begin : g_md_field
		$error("srx_sequencer_rx_exit: status mode field width differs from its type");
	end
	// Every event index must land inside the flag vector
	if (`SRX_EV_BUF_EMPTY >= `SRX_EVENT_COUNT) begin : g_ev_buf
		$error("srx_sequencer_rx_exit: buffer-empty index outside the flag vector");
	end
	if (`SRX_EV_TO_SYNC >= `SRX_EVENT_COUNT) begin : g_ev_sync
		$error("srx_sequencer_rx_exit: sync-timeout index outside the flag vector");
	end

	srx_regfile u_regs (
		.mclk       (mclk),
		.rst        (rst),
		.ce         (ce),
		.addr       (addr),
		.wdata      (wdata),
		.wr         (wr),
		.rd         (rd),
		.rdata      (rdata),
		.seqState   (r.state),
		.chipMode   (r.mode),
		.exitCfg    (exitCfg),
		.lpSel      (lpSel),
		.idleMode   (idleMode),
		.startPulse (startPulse),
		.stopPulse  (stopPulse)
	);

	// Flag vector in event-index order
	always_comb begin
		flags = '0;
		flags[`SRX_EV_PAYLOAD] = payloadCompleteFlag;
		flags[`SRX_EV_CHECKSUM] = checksumPassFlag;
		flags[`SRX_EV_RSSI] = rssiFlag;
		flags[`SRX_EV_SYNC] = syncWordMatchFlag;
		flags[`SRX_EV_PREAMBLE] = preambleFoundFlag;
		flags[`SRX_EV_TO_RSSI] = signalStrengthTimeout;
		flags[`SRX_EV_TO_PREAMBLE] = preambleTimeout;
		flags[`SRX_EV_TO_SYNC] = syncSignalTimeout;
		flags[`SRX_EV_BUF_EMPTY] = bufferEmptyFlag;
	end

	// Edge detection so that a lingering flag cannot retrigger
	srx_event_edge #(
		.N (`SRX_EVENT_COUNT)
	) u_edge (
		.mclk  (mclk),
		.rst   (rst),
		.ce    (ce),
		.flags (flags),
		.rise  (rise)
	);

	// Unused codes fall to the default branches of the state machine
	assign rxExit = srx_rx_exit_e'(exitCfg[`SRX_RX_EXIT_HI:`SRX_RX_EXIT_LO]);
	assign toExit = srx_to_exit_e'(exitCfg[`SRX_TO_EXIT_HI:`SRX_TO_EXIT_LO]);
	assign prExit = srx_pr_exit_e'(exitCfg[`SRX_PR_EXIT_HI:`SRX_PR_EXIT_LO]);

	assign receive_timeout_event = rise[`SRX_EV_TO_RSSI] | rise[`SRX_EV_TO_PREAMBLE]
		| rise[`SRX_EV_TO_SYNC];

	// Target of a low-power-selection transition
	always_comb begin
		if (lpSel) begin
			lpState = ST_IDLE;
			lpMode = idleMode ? MODE_SLEEP : MODE_STANDBY;
		end else begin
			lpState = ST_HALTED;
			lpMode = MODE_INITIAL;
		end
	end

	function automatic srx_main_s goTo(
		input srx_main_s  cur,
		input srx_state_e st,
		input srx_mode_e  md
	);
		srx_main_s res;
		res = cur;
		res.state = st;
		res.mode = md;
		res.fired = 1'b1;
		// A relaunch pulse must not ride along on a later move
		res.relaunch = 1'b0;
		return res;
	endfunction

	// Action of the timeout-exit field
	function automatic srx_main_s timeoutExit(
		input srx_main_s    cur,
		input srx_to_exit_e sel,
		input srx_state_e   lpSt,
		input srx_mode_e    lpMd
	);
		srx_main_s res;
		res = cur;
		case (sel)
			TO_RELAUNCH: begin
				res = goTo(cur, ST_RECEIVE, MODE_ACTIVE);
				res.relaunch = 1'b1;
			end
			TO_TRANSMIT: res = goTo(cur, ST_TRANSMIT, MODE_ACTIVE);
			TO_LOWPOWER: res = goTo(cur, lpSt, lpMd);
			TO_HALT:     res = goTo(cur, ST_HALTED, MODE_INITIAL);
			default:     res = cur;
		endcase
		return res;
	endfunction

	always_comb begin
		n = r;
		n.relaunch = 1'b0;
		n.fired = 1'b0;
		if (stopPulse) begin
			n = goTo(r, ST_HALTED, MODE_INITIAL);
		end else begin
			case (r.state)
				ST_HALTED, ST_IDLE: begin
					// Halted or idle: no exit is evaluated, only a start
					if (startPulse) begin
						n = goTo(r, ST_RECEIVE, MODE_ACTIVE);
					end
				end
				ST_RECEIVE: begin
					// Selector event outranks a coincident timeout
					case (rxExit)
						RX_PAY_PKT: begin
							if (rise[`SRX_EV_PAYLOAD]) begin
								n = goTo(r, ST_PKT_RCVD, MODE_ACTIVE);
							end else if (receive_timeout_event) begin
								n = timeoutExit(r, toExit, lpState, lpMode);
							end
						end
						RX_PAY_LP: begin
							if (rise[`SRX_EV_PAYLOAD]) begin
								n = goTo(r, lpState, lpMode);
							end else if (receive_timeout_event) begin
								n = timeoutExit(r, toExit, lpState, lpMode);
							end
						end
						RX_CRC_PKT: begin
							if (rise[`SRX_EV_CHECKSUM]) begin
								n = goTo(r, ST_PKT_RCVD, MODE_ACTIVE);
							end else if (rise[`SRX_EV_PAYLOAD] || receive_timeout_event) begin
								// Payload done without checksum pass
								n = timeoutExit(r, toExit, lpState, lpMode);
							end
						end
						RX_RSSI_OFF: begin
							if (rise[`SRX_EV_RSSI]) begin
								n = goTo(r, ST_HALTED, MODE_INITIAL);
							end else if (receive_timeout_event) begin
								n = timeoutExit(r, toExit, lpState, lpMode);
							end
						end
						RX_SYNC_OFF: begin
							if (rise[`SRX_EV_SYNC]) begin
								n = goTo(r, ST_HALTED, MODE_INITIAL);
							end else if (receive_timeout_event) begin
								n = timeoutExit(r, toExit, lpState, lpMode);
							end
						end
						RX_PRE_OFF: begin
							if (rise[`SRX_EV_PREAMBLE]) begin
								n = goTo(r, ST_HALTED, MODE_INITIAL);
							end else if (receive_timeout_event) begin
								n = timeoutExit(r, toExit, lpState, lpMode);
							end
						end
						default: begin
							// Unused selector codes leave only the timeout exit
							if (receive_timeout_event) begin
								n = timeoutExit(r, toExit, lpState, lpMode);
							end
						end
					endcase
				end
				ST_PKT_RCVD: begin
					// Codes 000, 010, 011 and 100 leave on the first edge, no event
					case (prExit)
						PR_HALT: n = goTo(r, ST_HALTED, MODE_INITIAL);
						PR_TX_EMPTY: begin
							if (rise[`SRX_EV_BUF_EMPTY]) begin
								n = goTo(r, ST_TRANSMIT, MODE_ACTIVE);
							end
						end
						PR_LOWPOWER: n = goTo(r, lpState, lpMode);
						PR_RX_SYNTH: begin
							if (freqChanged) begin
								n = goTo(r, ST_SYNTH, MODE_ACTIVE);
							end else begin
								n = goTo(r, ST_RECEIVE, MODE_ACTIVE);
							end
						end
						PR_RX_DIRECT: n = goTo(r, ST_RECEIVE, MODE_ACTIVE);
						default: n = n;
					endcase
				end
				ST_SYNTH: begin
					// Receive resumes only once the synthesizer settles
					if (synthReady) begin
						n = goTo(r, ST_RECEIVE, MODE_ACTIVE);
					end
				end
				// Transmit is left only through a stop; its exits live elsewhere
				ST_TRANSMIT: n = n;
				default: n = goTo(r, ST_HALTED, MODE_INITIAL);
			endcase
		end
	end

	// Every transition above happens on a single enabled edge
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			r <= '{state: ST_HALTED, mode: MODE_INITIAL, default: '0};
		end else if (ce) begin
			r <= n;
		end
	end

	assign seqState = r.state;
	assign chipMode = r.mode;
	assign receiveRelaunch = r.relaunch;
	assign transitionFired = r.fired;
endmodule

// ---- sim/srx_rx_exit_props.sv ----
// Port-level assertions for the receive-exit sequencer
`timescale 1ns/1ps
`include "srx_defines.svh"
module srx_rx_exit_props
	import srx_pkg::*;
(
	input wire logic       mclk,
	input wire logic       rst,
	input wire logic       ce,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	input wire logic       payloadCompleteFlag,
	input wire logic       checksumPassFlag,
	input wire logic       rssiFlag,
	input wire logic       syncWordMatchFlag,
	input wire logic       preambleFoundFlag,
	input wire logic       signalStrengthTimeout,
	input wire logic       preambleTimeout,
	input wire logic       syncSignalTimeout,
	input wire logic       bufferEmptyFlag,
	input wire logic       freqChanged,
	input wire logic       synthReady,
	input srx_state_e      seqState,
	input srx_mode_e       chipMode,
	input wire logic       receiveRelaunch,
	input wire logic       transitionFired
);
	logic [7:0] cfg;
	logic [7:0] aP;
	logic [8:0] pv;
	logic       rdP;
	logic       cw1;
	logic       cw2;
	logic [8:0] f;
	logic [8:0] up;
	logic       cw;
	logic       q;
	logic       inRx;
	assign f = {bufferEmptyFlag, syncSignalTimeout, preambleTimeout, signalStrengthTimeout,
		preambleFoundFlag, syncWordMatchFlag, rssiFlag, checksumPassFlag, payloadCompleteFlag};
	assign up = f & ~pv;
	assign cw = wr && addr == `SRX_ADDR_CTRL;
	// Control writes may start or stop the sequencer, so they mask the checks
	assign q = ce && !cw && !cw1 && !cw2;
	assign inRx = seqState == ST_RECEIVE;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cfg <= 8'h00;
			aP <= 8'h00;
			pv <= '0;
			rdP <= 1'b0;
			cw1 <= 1'b0;
			cw2 <= 1'b0;
		end else if (ce) begin
			if (wr && addr == `SRX_ADDR_EXIT_CFG)
				cfg <= wdata;
			aP <= addr;
			pv <= f;
			rdP <= rd;
			cw1 <= cw;
			cw2 <= cw1;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	property p_sel_pkt;
		q && inRx && ((cfg[7:5] == 3'b001 && up[0]) || (cfg[7:5] == 3'b011 && up[1]))
			|=> seqState == ST_PKT_RCVD && transitionFired;
	endproperty
	a_sel_pkt: assert property (p_sel_pkt) else $error("packet exit missed");
	property p_sel_halt;
		q && inRx && ((cfg[7:5] == 3'b100 && up[2]) || (cfg[7:5] == 3'b101 && up[3])
			|| (cfg[7:5] == 3'b110 && up[4])) |=> seqState == ST_HALTED;
	endproperty
	a_sel_halt: assert property (p_sel_halt) else $error("halt exit missed");
	property p_to_exit;
		q && inRx && cfg[7:5] == 3'b000 && cfg[4:3] != 2'b10 && |up[7:5]
			|=> seqState == (cfg[4] ? ST_HALTED : (cfg[3] ? ST_TRANSMIT : ST_RECEIVE));
	endproperty
	a_to_exit: assert property (p_to_exit) else $error("timeout exit wrong");
	property p_relaunch;
		receiveRelaunch |-> inRx && transitionFired;
	endproperty
	a_relaunch: assert property (p_relaunch) else $error("relaunch outside receive");
	property p_pr_halt;
		q && seqState == ST_PKT_RCVD && cfg[2:0] == 3'b000 |=> seqState == ST_HALTED;
	endproperty
	a_pr_halt: assert property (p_pr_halt) else $error("packet halt missed");
	property p_pr_rx;
		q && seqState == ST_PKT_RCVD && cfg[2:0] == 3'b100 |=> inRx [*2];
	endproperty
	a_pr_rx: assert property (p_pr_rx) else $error("packet return missed");
	property p_idle_hold;
		q && seqState inside {ST_HALTED, ST_IDLE} |=> $stable(seqState);
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("left halted unasked");
	property p_rd_cfg;
		rdP && aP == `SRX_ADDR_EXIT_CFG |-> rdata == cfg;
	endproperty
	a_rd_cfg: assert property (p_rd_cfg) else $error("config readback wrong");
	property p_rd_idle;
		!rdP |-> rdata == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");

	c_pkt: cover property (inRx ##1 seqState == ST_PKT_RCVD);
	c_relaunch: cover property (receiveRelaunch);
	c_synth: cover property (seqState == ST_SYNTH ##[1:8] inRx);
endmodule

bind srx_sequencer_rx_exit srx_rx_exit_props u_props (
	.mclk                  (mclk),
	.rst                   (rst),
	.ce                    (ce),
	.addr                  (addr),
	.wdata                 (wdata),
	.wr                    (wr),
	.rd                    (rd),
	.rdata                 (rdata),
	.payloadCompleteFlag   (payloadCompleteFlag),
	.checksumPassFlag      (checksumPassFlag),
	.rssiFlag              (rssiFlag),
	.syncWordMatchFlag     (syncWordMatchFlag),
	.preambleFoundFlag     (preambleFoundFlag),
	.signalStrengthTimeout (signalStrengthTimeout),
	.preambleTimeout       (preambleTimeout),
	.syncSignalTimeout     (syncSignalTimeout),
	.bufferEmptyFlag       (bufferEmptyFlag),
	.freqChanged           (freqChanged),
	.synthReady            (synthReady),
	.seqState              (seqState),
	.chipMode              (chipMode),
	.receiveRelaunch       (receiveRelaunch),
	.transitionFired       (transitionFired)
);

// ---- sim/srx_sequencer_rx_exit_test.sv ----
// Self-checking bench for the receive-exit sequencer
`timescale 1ns/1ps
`include "srx_defines.svh"
module srx_sequencer_rx_exit_test;
	import srx_pkg::*;
	logic       mclk, rst, ce, wr, rd, freqChanged, synthReady;
	logic [7:0] addr, wdata, rdata;
	logic [8:0] fl;
	srx_state_e seqState;
	srx_mode_e  chipMode;
	logic       receiveRelaunch, transitionFired;
	int         n_errors, checked;

	srx_sequencer_rx_exit u_dut (.mclk(mclk), .rst(rst), .ce(ce), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .payloadCompleteFlag(fl[0]),
		.checksumPassFlag(fl[1]), .rssiFlag(fl[2]), .syncWordMatchFlag(fl[3]),
		.preambleFoundFlag(fl[4]), .signalStrengthTimeout(fl[5]), .preambleTimeout(fl[6]),
		.syncSignalTimeout(fl[7]), .bufferEmptyFlag(fl[8]), .freqChanged(freqChanged),
		.synthReady(synthReady), .seqState(seqState), .chipMode(chipMode),
		.receiveRelaunch(receiveRelaunch), .transitionFired(transitionFired));

	task automatic report_and_stop();
		if (n_errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		chk(rdata, e);
	endtask
	// Bounded wait; a stuck sequencer ends the run
	task automatic wait_st(input srx_state_e e);
		repeat (8) if (seqState !== e) begin
			@(posedge mclk);
			#1;
		end
		chk(seqState, e);
		if (seqState !== e)
			report_and_stop();
	endtask
	task automatic fire(input int ev);
		@(posedge mclk);
		fl[ev] <= 1'b1;
		@(posedge mclk);
		#1;
	endtask
	task automatic run(input logic [7:0] cfg, input logic [7:0] ctl, input int ev,
		input srx_state_e e, input srx_mode_e md, input bit m);
		wreg(`SRX_ADDR_CTRL, 8'h02);
		wreg(`SRX_ADDR_EXIT_CFG, cfg);
		fl <= '0;
		wreg(`SRX_ADDR_CTRL, ctl | 8'h01);
		wait_st(ST_RECEIVE);
		fire(ev);
		chk(seqState, e);
		chk(receiveRelaunch, e == ST_RECEIVE && ev >= 5);
		chk(transitionFired, e != ST_RECEIVE || ev >= 5);
		if (m)
			chk(chipMode, md);
	endtask
	// Packet-received exit, then two more cycles to see no second firing
	task automatic pr_case(input logic [2:0] pr, input srx_state_e e);
		run({5'b01100, pr}, 8'h00, 1, ST_PKT_RCVD, MODE_INITIAL, 0);
		repeat (2) begin
			@(posedge mclk);
			#1;
			chk(seqState, e);
		end
	endtask
	// Enable low freezes the sequencer; the pending edge fires once it returns
	task automatic freeze_case();
		wreg(`SRX_ADDR_CTRL, 8'h02);
		wreg(`SRX_ADDR_EXIT_CFG, 8'h20);
		fl <= '0;
		wreg(`SRX_ADDR_CTRL, 8'h01);
		wait_st(ST_RECEIVE);
		@(posedge mclk);
		ce <= 1'b0;
		fl[0] <= 1'b1;
		repeat (3) @(posedge mclk);
		#1;
		chk(seqState, ST_RECEIVE);
		@(posedge mclk);
		ce <= 1'b1;
		@(posedge mclk);
		#1;
		chk(seqState, ST_PKT_RCVD);
	endtask
	// Reset in mid-run returns the configuration and the state to their reset values
	task automatic reset_case();
		@(posedge mclk);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		rreg(`SRX_ADDR_EXIT_CFG, `SRX_EXIT_CFG_RESET);
		rreg(`SRX_ADDR_STATUS, 8'h00);
	endtask

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	initial begin
		{rst, ce, wr, rd, freqChanged, synthReady} = 6'b110000;
		{addr, wdata, fl} = '0;
		n_errors = 0;
		checked = 0;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		rreg(8'h37, 8'h00);
		rreg(8'h3f, 8'h00);
		rreg(8'h50, 8'h00);
		wreg(8'h37, 8'ha5);
		rreg(8'h37, 8'ha5);
		wreg(8'h3f, 8'hff);
		rreg(8'h3f, 8'h00);
		run(8'h20, 8'h00, 0, ST_PKT_RCVD, MODE_INITIAL, 0);
		run(8'h40, 8'h04, 0, ST_IDLE, MODE_STANDBY, 1);
		run(8'h40, 8'h0c, 0, ST_IDLE, MODE_SLEEP, 1);
		run(8'h60, 8'h00, 1, ST_PKT_RCVD, MODE_INITIAL, 0);
		run(8'h80, 8'h00, 2, ST_HALTED, MODE_INITIAL, 0);
		run(8'ha0, 8'h00, 3, ST_HALTED, MODE_INITIAL, 0);
		run(8'hc0, 8'h00, 4, ST_HALTED, MODE_INITIAL, 0);
		run(8'h08, 8'h00, 5, ST_TRANSMIT, MODE_INITIAL, 0);
		run(8'h18, 8'h00, 6, ST_HALTED, MODE_INITIAL, 0);
		run(8'h00, 8'h00, 7, ST_RECEIVE, MODE_INITIAL, 0);
		run(8'h70, 8'h00, 0, ST_HALTED, MODE_INITIAL, 1);
		run(8'he0, 8'h00, 0, ST_RECEIVE, MODE_INITIAL, 0);
		freeze_case();
		pr_case(3'b000, ST_HALTED);
		pr_case(3'b010, ST_HALTED);
		pr_case(3'b100, ST_RECEIVE);
		pr_case(3'b001, ST_PKT_RCVD);
		fire(8);
		chk(seqState, ST_TRANSMIT);
		@(posedge mclk);
		freqChanged <= 1'b1;
		pr_case(3'b011, ST_SYNTH);
		@(posedge mclk);
		synthReady <= 1'b1;
		wait_st(ST_RECEIVE);
		@(posedge mclk);
		{freqChanged, synthReady} <= 2'b00;
		pr_case(3'b011, ST_RECEIVE);
		wreg(8'h3e, 8'h02);
		fire(0);
		chk(seqState, ST_HALTED);
		reset_case();
		report_and_stop();
	end
endmodule
